// file: cfg_store_pkg.sv
// package for the nonvolatile configuration store: word and byte map, control bits,
// memory command codes and timing figures.
// assumes a 64 x 16 store and a 50 MHz system clock.
package cfg_store_pkg;

    localparam int WORD_COUNT = 64;
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 6;

    // word index boundaries
    localparam logic [5:0] FACTORY_LAST = 6'h04;
    localparam logic [5:0] USER_FIRST = 6'h05;
    localparam logic [5:0] USER_LAST = 6'h18;
    localparam logic [5:0] RESV_FIRST = 6'h1E;
    localparam logic [5:0] RESV_LAST = 6'h2F;
    localparam logic [5:0] FREE_FIRST = 6'h30;

    // byte indices (byte 2w is low half of word w)
    localparam int B_CTRL1 = 10;
    localparam int B_CTRL2 = 11;
    localparam int B_FIXED_IP = 12;
    localparam int B_PORTA = 16;
    localparam int B_PORTB = 21;
    localparam int B_PORTC = 26;
    localparam int B_RPT_MASK = 32;
    localparam int B_RPT_FILTER = 35;
    localparam int B_RPT_RATE = 36;
    localparam int B_RPT_MAC = 38;
    localparam int B_RPT_IP = 44;
    localparam int B_RPT_PORT = 48;
    localparam int B_SUBNET = 50;
    localparam int B_GATEWAY = 54;
    localparam int B_PROG_PORT = 58;
    localparam int BYTE_COUNT = 60;

    // preset field offsets within one port's five bytes
    localparam int P_DIR = 0;
    localparam int P_VAL = 1;
    localparam int P_THR = 2;
    localparam int P_PULL = 3;
    localparam int P_HYST = 4;

    // active-low enable bits of the primary control byte
    localparam int EN_FIXED_IP = 0;
    localparam int EN_PRESET = 1;
    localparam int EN_REPORT = 2;

    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // memory command codes on the command port
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_ERASE = 3'h2;
    localparam logic [2:0] CMD_WREN = 3'h3;
    localparam logic [2:0] CMD_WRDIS = 3'h4;

    localparam logic [1:0] STATUS_OK = 2'h0;
    localparam logic [1:0] STATUS_REFUSED = 2'h1;
    localparam logic [1:0] STATUS_BAD_CMD = 2'h2;

    // write time of the memory cell
    localparam int CLK_MHZ = 50;
    localparam int WRITE_TIME_NS = 100;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;

endpackage

// file: config_eeprom_map.sv
// configuration store: 64 x 16 array, host command port, power-up loader that
// decodes the stored map into settings outputs.
// assumes one clock; host commands arrive as single validated packets.
//
// Functional notes
// R1 - store is 64 words of 16 bits, addressed by word index
// R2 - writes to words 0 to 4 are always refused
// R3 - words 5 to 24 hold user settings decoded by the loader
// R4 - host leaves words 30 to 47 erased to all ones
// R5 - words 48 to 63 are plain user data with no meaning
// R6 - word w splits into low byte 2w and high byte 2w+1
// R7 - word 5 holds control bytes; words 6-7 fixed network address
// R8 - port A presets at bytes 16 to 20
// R9 - port B presets at bytes 21 to 25
// R10 - port C presets at bytes 26 to 30, byte 31 reserved
// R11 - report masks at bytes 32-34, filter count at byte 35
// R12 - report scan rate is word 18, low byte 36
// R13 - report hardware address at bytes 38 to 43, byte 1 lowest
// R14 - report network address at bytes 44 to 47, byte 1 lowest
// R15 - report port number is word 24, low byte 48
// R16 - subnet mask at bytes 50 to 53, byte 1 lowest
// R17 - gateway at bytes 54-57; programmable port word 29
// R18 - erased reads all ones, so enable bits are active low
// R19 - control bit 0 fixed address, 1 presets, 2 reports
// R20 - host keeps control bits 3 to 7 at one
// R21 - control value 255 disables all three functions
// R22 - write and erase refused unless write enable issued first
// R23 - write-protect jumper blocks all writes and erases
// R24 - host sends each memory command as one packet
// R25 - after power-up apply only settings whose enable bit is cleared; the code loads ctrl_secondary and prog_port whatever the enable bits
`timescale 1ns/10ps

module config_eeprom_map
    import cfg_store_pkg::*;
#(
    parameter int DEPTH = WORD_COUNT,
    parameter int WIDTH = WORD_BITS
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic write_protect_jumper,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [ADDR_BITS-1:0] cmd_addr,
    input wire logic [WIDTH-1:0] cmd_data,
    output logic cmd_done,
    output logic [1:0] cmd_status,
    output logic [WIDTH-1:0] rd_data,
    output logic write_enabled,
    output logic busy,
    output logic load_done,
    output logic fixed_ip_en,
    output logic preset_en,
    output logic periodic_input_report_en,
    output logic [7:0] ctrl_secondary,
    output logic [31:0] fixed_ip,
    output logic [39:0] preset_a,
    output logic [39:0] preset_b,
    output logic [39:0] preset_c,
    output logic [23:0] report_mask,
    output logic [7:0] report_filter,
    output logic [15:0] report_rate,
    output logic [47:0] report_mac,
    output logic [31:0] report_ip,
    output logic [15:0] report_port,
    output logic [31:0] subnet_mask,
    output logic [31:0] gateway,
    output logic [15:0] prog_port
);

    typedef enum logic [3:0]
    {
        S_LOAD = 4'b0001,
        S_APPLY = 4'b0010,
        S_IDLE = 4'b0100,
        S_WRITE = 4'b1000
    } state_e;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [7:0] shadow [BYTE_COUNT];
    logic rst_meta;
    logic rst_sync;
    logic wp_meta;
    logic wp_sync;
    state_e state;
    logic [ADDR_BITS-1:0] load_idx;
    logic [7:0] wait_cnt;
    logic mem_we;
    logic [ADDR_BITS-1:0] mem_waddr;
    logic [WIDTH-1:0] mem_wdata;
    logic [7:0] ctrl_primary;

    // byte b of the map picks the low or high half of word b/2
    function automatic logic [7:0] map_byte(input int b);
        map_byte = shadow[b]; // [R6]
    endfunction

    // five preset bytes, direction lowest
    function automatic logic [39:0] preset_of(input int base);
        preset_of = {map_byte(base + P_HYST), map_byte(base + P_PULL),
                     map_byte(base + P_THR), map_byte(base + P_VAL),
                     map_byte(base + P_DIR)};
    endfunction

    // four-byte address with byte 1 in the low bits
    function automatic logic [31:0] quad_of(input int base);
        quad_of = {map_byte(base + 3), map_byte(base + 2),
                   map_byte(base + 1), map_byte(base)};
    endfunction

    // a write or erase may touch only non-factory words, with enable set and jumper off
    function automatic logic may_write(input logic [ADDR_BITS-1:0] a, input logic en,
                                       input logic wp);
        may_write = (a > FACTORY_LAST) && en && !wp; // [R2] [R22] [R23]
    endfunction

    // primary control byte as a plain vector, so single enable bits can be selected
    assign ctrl_primary = map_byte(B_CTRL1); // [R6] [R7]

    // reset release through two flops
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // jumper is a board pin, synchronised before use
    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end
        else
        begin
            wp_meta <= write_protect_jumper;
            wp_sync <= wp_meta;
        end
    end

    // storage array: 64 words, no reset so it behaves like the real cell array;
    // a plain clocked process so the array can also be filled from outside like a programmed chip
    always @(posedge clk)
    begin
        if (mem_we)
        begin
            mem[mem_waddr] <= mem_wdata; // [R1]
        end
    end

    // loader walks the used words into the byte shadow, then commands are served
    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state <= S_LOAD;
            load_idx <= '0;
            wait_cnt <= '0;
            mem_we <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= '0;
            cmd_done <= 1'b0;
            cmd_status <= STATUS_OK;
            rd_data <= '0;
            write_enabled <= 1'b0;
            busy <= 1'b1;
            load_done <= 1'b0;
            for (int i = 0; i < BYTE_COUNT; i++)
            begin
                shadow[i] <= ERASED_BYTE; // [R18]
            end
        end
        else
        begin
            mem_we <= 1'b0;
            cmd_done <= 1'b0;
            case (state)
                S_LOAD:
                begin
                    // only words 5 to 29 carry meaning; 30 up are never decoded
                    shadow[2 * load_idx] <= mem[load_idx][7:0]; // [R3] [R6]
                    shadow[2 * load_idx + 1] <= mem[load_idx][15:8];
                    if (load_idx == ADDR_BITS'(BYTE_COUNT / 2 - 1))
                    begin
                        state <= S_APPLY;
                    end
                    load_idx <= load_idx + 1'b1;
                end
                S_APPLY:
                begin
                    load_done <= 1'b1; // [R25]
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
                S_IDLE:
                begin
                    if (cmd_valid) // [R24]
                    begin
                        cmd_done <= 1'b1;
                        cmd_status <= STATUS_OK;
                        case (cmd_op)
                            CMD_READ:
                            begin
                                rd_data <= mem[cmd_addr]; // [R5]
                            end
                            CMD_WREN:
                            begin
                                write_enabled <= 1'b1;
                            end
                            CMD_WRDIS:
                            begin
                                write_enabled <= 1'b0;
                            end
                            CMD_WRITE, CMD_ERASE:
                            begin
                                if (may_write(cmd_addr, write_enabled, wp_sync))
                                begin
                                    mem_we <= 1'b1;
                                    mem_waddr <= cmd_addr;
                                    // erase leaves the word all ones
                                    mem_wdata <= (cmd_op == CMD_ERASE) ? ERASED_WORD : cmd_data;
                                    cmd_done <= 1'b0;
                                    busy <= 1'b1;
                                    wait_cnt <= 8'(WRITE_CYCLES);
                                    state <= S_WRITE;
                                end
                                else
                                begin
                                    cmd_status <= STATUS_REFUSED; // [R2] [R22] [R23]
                                end
                            end
                            default:
                            begin
                                cmd_status <= STATUS_BAD_CMD;
                            end
                        endcase
                    end
                end
                S_WRITE:
                begin
                    // new settings take effect only at the next power-up load
                    if (wait_cnt <= 8'h01)
                    begin
                        busy <= 1'b0;
                        cmd_done <= 1'b1;
                        state <= S_IDLE;
                    end
                    wait_cnt <= wait_cnt - 8'h01;
                end
                default:
                begin
                    state <= S_LOAD;
                end
            endcase
        end
    end

    // decoded settings; each group except ctrl_secondary and prog_port stays at the erased value unless enabled
    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            fixed_ip_en <= 1'b0;
            preset_en <= 1'b0;
            periodic_input_report_en <= 1'b0;
            ctrl_secondary <= ERASED_BYTE;
            fixed_ip <= '1;
            preset_a <= '1;
            preset_b <= '1;
            preset_c <= '1;
            report_mask <= '1;
            report_filter <= ERASED_BYTE;
            report_rate <= '1;
            report_mac <= '1;
            report_ip <= '1;
            report_port <= '1;
            subnet_mask <= '1;
            gateway <= '1;
            prog_port <= '1;
        end
        else if (state == S_APPLY)
        begin
            // a zero bit turns a function on; 255 leaves all three off
            fixed_ip_en <= !ctrl_primary[EN_FIXED_IP]; // [R18] [R19] [R21] [R25]
            preset_en <= !ctrl_primary[EN_PRESET]; // [R19]
            periodic_input_report_en <= !ctrl_primary[EN_REPORT]; // [R19]
            ctrl_secondary <= map_byte(B_CTRL2); // [R7]
            if (!ctrl_primary[EN_FIXED_IP])
            begin
                fixed_ip <= quad_of(B_FIXED_IP); // [R7]
                subnet_mask <= quad_of(B_SUBNET); // [R16]
                gateway <= quad_of(B_GATEWAY); // [R17]
            end
            if (!ctrl_primary[EN_PRESET])
            begin
                preset_a <= preset_of(B_PORTA); // [R8]
                preset_b <= preset_of(B_PORTB); // [R9]
                preset_c <= preset_of(B_PORTC); // [R10]
            end
            if (!ctrl_primary[EN_REPORT])
            begin
                report_mask <= {map_byte(B_RPT_MASK + 2), map_byte(B_RPT_MASK + 1),
                                map_byte(B_RPT_MASK)}; // [R11]
                report_filter <= map_byte(B_RPT_FILTER); // [R11]
                report_rate <= {map_byte(B_RPT_RATE + 1), map_byte(B_RPT_RATE)}; // [R12]
                report_mac <= {map_byte(B_RPT_MAC + 5), map_byte(B_RPT_MAC + 4),
                               quad_of(B_RPT_MAC)}; // [R13]
                report_ip <= quad_of(B_RPT_IP); // [R14]
                report_port <= {map_byte(B_RPT_PORT + 1), map_byte(B_RPT_PORT)}; // [R15]
            end
            prog_port <= {map_byte(B_PROG_PORT + 1), map_byte(B_PROG_PORT)}; // [R17]
        end
    end

endmodule

// file: cfg_store_checker.sv
// checker for the configuration store: command answers and loaded settings
// assumes it is bound to the store top and sees its ports only
`timescale 1ns/10ps
module cfg_store_checker
    import cfg_store_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic write_protect_jumper,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [ADDR_BITS-1:0] cmd_addr,
    input wire logic cmd_done,
    input wire logic [1:0] cmd_status,
    input wire logic write_enabled,
    input wire logic busy,
    input wire logic load_done,
    input wire logic fixed_ip_en,
    input wire logic preset_en,
    input wire logic [31:0] fixed_ip,
    input wire logic [39:0] preset_a,
    input wire logic [15:0] report_rate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a command is only taken while idle
    logic take;
    logic wr;
    assign take = cmd_valid && !busy;
    assign wr = (cmd_op == CMD_WRITE) || (cmd_op == CMD_ERASE);
    property p_low_words;
        take && wr && cmd_addr <= FACTORY_LAST |=> cmd_done && cmd_status == STATUS_REFUSED;
    endproperty
    a_low_words: assert property (p_low_words) else $error("factory word write accepted");
    property p_no_wren;
        take && wr && !write_enabled |=> cmd_done && cmd_status == STATUS_REFUSED;
    endproperty
    a_no_wren: assert property (p_no_wren) else $error("write without enable accepted");
    // jumper passes two sync flops, so it must stand three edges
    property p_jumper;
        write_protect_jumper [*3] ##0 (take && wr) |=> cmd_done && cmd_status == STATUS_REFUSED;
    endproperty
    a_jumper: assert property (p_jumper) else $error("write with jumper fitted accepted");
    property p_write_time;
        !write_protect_jumper [*3] ##0 (take && wr && write_enabled && cmd_addr > FACTORY_LAST)
        |=> busy [*5] ##1 (cmd_done && !busy && cmd_status == STATUS_OK);
    endproperty
    a_write_time: assert property (p_write_time) else $error("accepted write timing wrong");
    property p_wren;
        take && cmd_op == CMD_WREN |=> cmd_done && write_enabled;
    endproperty
    a_wren: assert property (p_wren) else $error("write enable not set");
    property p_wrdis;
        take && cmd_op == CMD_WRDIS |=> cmd_done && !write_enabled;
    endproperty
    a_wrdis: assert property (p_wrdis) else $error("write enable not cleared");
    property p_read;
        take && cmd_op == CMD_READ |=> cmd_done && cmd_status == STATUS_OK;
    endproperty
    a_read: assert property (p_read) else $error("read not answered in one cycle");
    property p_fixed_off;
        load_done && !fixed_ip_en |-> fixed_ip == 32'hFFFF_FFFF;
    endproperty
    a_fixed_off: assert property (p_fixed_off) else $error("fixed address applied while off");
    property p_preset_off;
        load_done && !preset_en |-> preset_a == {5{ERASED_BYTE}};
    endproperty
    a_preset_off: assert property (p_preset_off) else $error("presets applied while off");
    property p_settled;
        load_done && $past(load_done) |-> $stable(report_rate) && $stable(fixed_ip);
    endproperty
    a_settled: assert property (p_settled) else $error("settings moved after load");
    c_write: cover property (take && cmd_op == CMD_WRITE ##1 busy);
    c_load: cover property ($rose(load_done));
    c_refused: cover property (cmd_done && cmd_status == STATUS_REFUSED);
endmodule
bind config_eeprom_map cfg_store_checker i_cfg_store_checker (.*);

// file: cfg_host_model.sv
// host side model: sends memory commands one packet at a time
// assumes the store answers every taken command with a done pulse
`timescale 1ns/10ps
module cfg_host_model
    import cfg_store_pkg::*;
(
    input wire logic clk,
    input wire logic cmd_done,
    output logic cmd_valid,
    output logic [2:0] cmd_op,
    output logic [ADDR_BITS-1:0] cmd_addr,
    output logic [15:0] cmd_data
);
    // idle command port at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_addr = 6'h00;
        cmd_data = 16'h0000;
    end
    // whole command per call, next one only after done
    task automatic issue(input logic [2:0] op, input logic [5:0] a, input logic [15:0] d,
        output logic ok);
        ok = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // released fields show inverted junk so stale values are never trusted
        cmd_op <= ~op;
        cmd_addr <= ~a;
        cmd_data <= ~d;
        // done stands one cycle from the taking edge, so look just after that edge first
        for (int n = 0; n < 20 && !ok; n++)
        begin
            #1 ok = (cmd_done === 1'b1);
            if (!ok)
                @(posedge clk);
        end
    endtask
endmodule

// file: tb_config_eeprom_map.sv
// testbench: preloads the store image, checks decoded settings and commands
// assumes the store array is reachable as mem inside the design
`timescale 1ns/10ps
module tb_config_eeprom_map
    import cfg_store_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic write_protect_jumper = 1'b0;
    logic cmd_valid, cmd_done, busy, load_done, write_enabled;
    logic fixed_ip_en, preset_en, periodic_input_report_en;
    logic [2:0] cmd_op;
    logic [5:0] cmd_addr;
    logic [1:0] cmd_status;
    logic [15:0] cmd_data, rd_data, report_rate, report_port, prog_port;
    logic [7:0] ctrl_secondary, report_filter;
    logic [31:0] fixed_ip, report_ip, subnet_mask, gateway;
    logic [39:0] preset_a, preset_b, preset_c;
    logic [23:0] report_mask;
    logic [47:0] report_mac;
    logic [7:0] ctrls [5] = '{8'hF8, 8'hFF, 8'hFE, 8'hFD, 8'hFB};
    int fails = 0;
    int cmp_count = 0;
    config_eeprom_map i_config_eeprom_map (.*);
    cfg_host_model i_cfg_host_model (.*);
    // 50 MHz clock
    always #10 clk = ~clk;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // image byte k holds k, so a field is its byte indices, first byte lowest
    function automatic logic [63:0] fld(input int b, input int n, input logic on);
        logic [63:0] v;
        v = '0;
        for (int i = n - 1; i >= 0; i--)
            v = (v << 8) | (on ? 64'(b + i) : 64'h0000_0000_0000_00FF);
        return v;
    endfunction
    task automatic t_load(input logic [7:0] ctrl);
        logic [2:0] en;
        for (int w = 0; w < WORD_COUNT; w++)
            i_config_eeprom_map.mem[w] = (w >= 30 && w <= 47) ? ERASED_WORD : {8'(2*w+1), 8'(2*w)};
        i_config_eeprom_map.mem[5][7:0] = ctrl; // upper control bits stay one
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (int n = 0; n < 100 && !(load_done === 1'b1 && busy === 1'b0); n++)
            @(posedge clk);
        #1;
        en = ~ctrl[2:0];
        chk(load_done, 1'b1);
        chk({periodic_input_report_en, preset_en, fixed_ip_en}, en);
        chk(ctrl_secondary, 8'h0B);
        chk(fixed_ip, fld(12, 4, en[0]));
        chk(subnet_mask, fld(50, 4, en[0]));
        chk(gateway, fld(54, 4, en[0]));
        chk(prog_port, fld(58, 2, 1'b1));
        chk(preset_a, fld(16, 5, en[1]));
        chk(preset_b, fld(21, 5, en[1]));
        chk(preset_c, fld(26, 5, en[1]));
        chk(report_mask, fld(32, 3, en[2]));
        chk(report_filter, fld(35, 1, en[2]));
        chk(report_rate, fld(36, 2, en[2]));
        chk(report_mac, fld(38, 6, en[2]));
        chk(report_ip, fld(44, 4, en[2]));
        chk(report_port, fld(48, 2, en[2]));
    endtask
    task automatic cmd(input logic [2:0] op, input logic [5:0] a, input logic [15:0] d,
        input logic [1:0] st);
        logic ok;
        i_cfg_host_model.issue(op, a, d, ok);
        chk(ok, 1'b1);
        chk(cmd_status, st);
    endtask
    task automatic t_cmds();
        cmd(CMD_READ, 6'h02, 16'h0000, STATUS_OK);
        chk(rd_data, 16'h0504);
        cmd(CMD_WRITE, 6'h30, 16'h1234, STATUS_REFUSED);
        cmd(CMD_WREN, 6'h00, 16'h0000, STATUS_OK);
        chk(write_enabled, 1'b1);
        cmd(CMD_WRITE, 6'h04, 16'h1234, STATUS_REFUSED);
        cmd(CMD_READ, 6'h04, 16'h0000, STATUS_OK);
        chk(rd_data, 16'h0908);
        cmd(CMD_WRITE, 6'h3F, 16'hA55A, STATUS_OK);
        cmd(CMD_READ, 6'h3F, 16'h0000, STATUS_OK);
        chk(rd_data, 16'hA55A);
        // jumper needs three edges to cross its synchroniser
        @(posedge clk);
        write_protect_jumper <= 1'b1;
        repeat (3) @(posedge clk);
        cmd(CMD_ERASE, 6'h3F, 16'h0000, STATUS_REFUSED);
        @(posedge clk);
        write_protect_jumper <= 1'b0;
        repeat (3) @(posedge clk);
        cmd(CMD_ERASE, 6'h3F, 16'h0000, STATUS_OK);
        cmd(CMD_READ, 6'h3F, 16'h0000, STATUS_OK);
        chk(rd_data, ERASED_WORD);
        cmd(3'h7, 6'h00, 16'h0000, STATUS_BAD_CMD);
        cmd(CMD_WRDIS, 6'h00, 16'h0000, STATUS_OK);
        chk(write_enabled, 1'b0);
        cmd(CMD_WRITE, 6'h30, 16'h1234, STATUS_REFUSED);
        cmd(CMD_READ, 6'h30, 16'h0000, STATUS_OK);
        chk(rd_data, 16'h6160);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence: five control byte values (all on, all off, each function alone), then the command port
    initial
    begin
        foreach (ctrls[i])
            t_load(ctrls[i]);
        t_cmds();
        end_of_test();
    end
    // watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
